// >>> hw/hint_table_writer.sv
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
// Operation
// - Header is at least sixteen bytes, growing with classes and lanes.
// - Header bytes 0 to 7 hold crystal time of the latest update.
// - Change byte for class c, capability p sits at 8 + total*c + p.
// - Entry i starts at 8 + (i+1) times the padded entry length.
// - Flag array and entries are padded to a multiple of eight.
// - Entry count never exceeds the logical processors on the socket.
// - Performance flag bit 0 marks a changed performance value.
// - Efficiency flag bit 0 marks a changed efficiency value.
// - Flag bit 1 asks software to force idle on processors.
// - Per class, performance flags come first, then efficiency.
// - No change byte exists for a capability not enumerated.
// - Identity bits 7:0 give the capability mask, 15:8 class count.
// - Identity bits 31:16 give the processor's own entry index; the code returns bits 2:0 of the value written to REG_IDENT_SEL there.
// - Layout stays compatible with the two-lane single-class format.
// - Each capability byte is an 8-bit level, zero meaning avoid.
module hint_table_writer
    import hint_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire upd_req_t upd,
    input wire logic upd_valid,
    output logic upd_ready,
    output mem_wr_t mem,
    output logic mem_valid,
    input wire logic mem_ready,
    input wire logic [63:0] crystal_time,
    output logic irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pub_state_t state, next_state;
    mem_wr_t next_mem;
    logic [31:0] ctrl, next_ctrl;
    logic [31:0] base, next_base;
    logic [3:0] entry_count, next_entry_count;
    logic [2:0] ident_sel, next_ident_sel;
    logic [1:0] status, next_status;
    logic [1:0] mask, next_mask;
    logic [63:0] last_stamp, next_last_stamp;
    logic [31:0] next_rdata;
    logic [ROW_BYTES-1:0] pend_chg, next_pend_chg;
    logic [ROW_BYTES-1:0] pend_idle, next_pend_idle;
    logic [7:0] shadow [LP_TOTAL][ROW_BYTES];
    logic shadow_we;
    logic [15:0] entry_offset;
    logic [2:0] lane;
    logic accept, bad_req, acc_change, acc_idle, published;
    logic [63:0] row_word;
    logic [63:0] flag_word;
    logic [7:0] flag_be;

    hint_layout u_layout (
        .lp(upd.lp),
        .cls(upd.cls),
        .cap(upd.cap),
        .entry_offset(entry_offset),
        .lane(lane)
    );

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    // Updates are taken only while idle, so a publish is never torn.
    assign upd_ready = ctrl[CTRL_ENABLE_BIT] && (state == ST_IDLE);
    assign accept = upd_valid && upd_ready;
    // Processors past the programmed entry count have no entry.
    // Lanes of classes not enumerated are refused.
    assign bad_req = ({1'b0, upd.lp} >= entry_count) ||
                     (int'(upd.cls) >= CATEGORY_TOTAL) ||
                     (int'(upd.cap) >= CAPABILITY_TOTAL);
    // Only a real change of the 8-bit level is published.
    assign acc_change = accept && !bad_req && !upd.idle &&
                        (shadow[upd.lp][lane] != upd.value);
    assign acc_idle = accept && !bad_req && upd.idle;
    assign shadow_we = acc_change;
    assign published = (state == ST_STAMP) && mem_ready;
    assign mem_valid = (state != ST_IDLE);

    always_comb begin
        row_word = 64'h0000_0000_0000_0000;
        for (int b = 0; b < ROW_BYTES; b++) begin
            row_word[b*8 +: 8] = shadow[upd.lp][b];
        end
        if (acc_change) begin
            row_word[int'(lane)*8 +: 8] = upd.value;
        end
    end

    // Flag bytes that have nothing pending are left unwritten, so a
    // byte that software is still reading is never overwritten by zero.
    // This relies on software zeroing the flags before use.
    always_comb begin
        flag_word = 64'h0000_0000_0000_0000;
        flag_be = 8'h00;
        for (int b = 0; b < ROW_BYTES; b++) begin
            // Bit 0 marks a change, including of bit 1.
            flag_word[b*8] = next_pend_chg[b] || next_pend_idle[b];
            // Bit 1 carries the idle request.
            flag_word[b*8+1] = next_pend_idle[b];
            flag_be[b] = next_pend_chg[b] || next_pend_idle[b];
        end
    end

    // ------------------------------------------------------------------
    // Publish sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_mem = mem;
        next_pend_chg = pend_chg;
        next_pend_idle = pend_idle;
        next_last_stamp = last_stamp;
        // Lane 2c is performance, lane 2c+1 efficiency.
        if (acc_change) begin
            next_pend_chg[lane] = 1'b1;
        end
        if (acc_idle) begin
            next_pend_idle[lane] = 1'b1;
        end
        case (state)
            ST_IDLE: begin
                // A changed value goes to memory before any flag.
                if (acc_change) begin
                    next_state = ST_ENTRY;
                    // Row bytes only; padding stays as zeroed.
                    next_mem.addr = base + 32'(entry_offset);
                    next_mem.data = row_word;
                    next_mem.byte_en = ROW_MASK;
                end else if (acc_idle) begin
                    next_state = ST_FLAGS;
                    // The flag array starts at byte 8.
                    next_mem.addr = base + 32'(FLAG_OFFSET);
                    next_mem.data = flag_word;
                    next_mem.byte_en = flag_be;
                end
            end
            ST_ENTRY: begin
                if (mem_ready) begin
                    next_state = ST_FLAGS;
                    next_mem.addr = base + 32'(FLAG_OFFSET);
                    next_mem.data = flag_word;
                    next_mem.byte_en = flag_be;
                end
            end
            ST_FLAGS: begin
                if (mem_ready) begin
                    // The stamp closes the update, written last.
                    next_state = ST_STAMP;
                    next_pend_chg = '0;
                    next_pend_idle = '0;
                    next_last_stamp = crystal_time;
                    // Crystal time into header bytes 0 to 7.
                    next_mem.addr = base + 32'(STAMP_OFFSET);
                    next_mem.data = crystal_time;
                    next_mem.byte_en = 8'hFF;
                end
            end
            ST_STAMP: begin
                if (mem_ready) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            mem <= '0;
            pend_chg <= '0;
            pend_idle <= '0;
            last_stamp <= 64'h0000_0000_0000_0000;
        end else begin
            state <= next_state;
            mem <= next_mem;
            pend_chg <= next_pend_chg;
            pend_idle <= next_pend_idle;
            last_stamp <= next_last_stamp;
        end
    end

    // The shadow mirrors the zeroed table, so it starts at zero too.
    // Values are stored as plain 8-bit levels.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < LP_TOTAL; i++) begin
                for (int b = 0; b < ROW_BYTES; b++) begin
                    shadow[i][b] <= 8'h00;
                end
            end
        end else if (shadow_we) begin
            shadow[upd.lp][lane] <= upd.value;
        end
    end

    // ------------------------------------------------------------------
    // Register port and interrupt
    // ------------------------------------------------------------------
    always_comb begin
        next_ctrl = ctrl;
        next_base = base;
        next_entry_count = entry_count;
        next_ident_sel = ident_sel;
        next_mask = mask;
        next_status = status;
        next_rdata = 32'h0000_0000;
        if (reg_write) begin
            case (reg_addr)
                REG_CTRL: next_ctrl = reg_wdata & 32'h0000_0001;
                REG_BASE: next_base = {reg_wdata[31:3], 3'b000};
                REG_ENTRIES: begin
                    // Larger counts are clamped to the socket size.
                    if (reg_wdata > 32'(LP_TOTAL)) begin
                        next_entry_count = 4'(LP_TOTAL);
                    end else begin
                        next_entry_count = reg_wdata[3:0];
                    end
                end
                REG_IDENT_SEL: next_ident_sel = reg_wdata[2:0];
                REG_INT_MASK: next_mask = reg_wdata[1:0];
                REG_INT_STATUS: next_status = status & ~reg_wdata[1:0];
                default: begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        if (published) begin
            next_status[ST_PUBLISHED_BIT] = 1'b1;
        end
        if (accept && bad_req) begin
            next_status[ST_DROPPED_BIT] = 1'b1;
        end
        if (reg_read) begin
            case (reg_addr)
                REG_CTRL: next_rdata = ctrl;
                REG_BASE: next_rdata = base;
                REG_ENTRIES: next_rdata = {28'h000_0000, entry_count};
                REG_IDENT_SEL: next_rdata = {29'h0000_0000, ident_sel};
                // Entry index, class count, capability mask.
                REG_IDENT: next_rdata = {13'h0000, ident_sel,
                    8'(CATEGORY_TOTAL), CAP_MASK};
                REG_INT_STATUS: next_rdata = {30'h0000_0000, status};
                REG_INT_MASK: next_rdata = {30'h0000_0000, mask};
                REG_STAMP_LO: next_rdata = last_stamp[31:0];
                REG_STAMP_HI: next_rdata = last_stamp[63:32];
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ctrl <= CTRL_RESET;
            base <= BASE_RESET;
            entry_count <= ENTRIES_RESET;
            ident_sel <= 3'h0;
            mask <= MASK_RESET;
            status <= 2'h0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl <= next_ctrl;
            base <= next_base;
            entry_count <= next_entry_count;
            ident_sel <= next_ident_sel;
            mask <= next_mask;
            status <= next_status;
            reg_rdata <= next_rdata;
        end
    end

    assign irq = |(status & mask);

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    chk_entry_then_flags: assert property (
        state == ST_ENTRY && mem_ready |=> state == ST_FLAGS)
        else $error("entry write not followed by flag write");
    chk_flags_then_stamp: assert property (
        state == ST_FLAGS && mem_ready |=> state == ST_STAMP ##0
        mem.data == $past(crystal_time))
        else $error("stamp missing or stale after flags");
    chk_stamp_addr: assert property (
        state == ST_STAMP |-> mem.addr == base && mem.byte_en == 8'hFF)
        else $error("stamp not at header bytes 0 to 7");
    chk_entry_place: assert property (
        acc_change |=> mem.addr ==
        $past(base) + 32'(FLAG_OFFSET + (int'($past(upd.lp)) + 1) * 8))
        else $error("entry written at wrong offset");
    chk_entry_pad: assert property (
        state == ST_ENTRY |-> mem.byte_en == 8'h3F && mem.addr[2:0] == 0)
        else $error("entry padding touched or misaligned");
    chk_flag_place: assert property (
        state == ST_FLAGS |-> mem.addr == base + 32'h0000_0008 &&
        (mem.byte_en & ~ROW_MASK) == 8'h00)
        else $error("flag array misplaced or unlisted lane written");
    chk_change_bit: assert property (
        acc_change ##1 mem_ready |=> state == ST_FLAGS &&
        mem.data[int'($past(lane, 2))*8] == 1'b1)
        else $error("change flag bit 0 not published");
    chk_idle_bit: assert property (
        acc_idle |=> mem.data[int'($past(lane))*8 +: 2] == 2'b11 &&
        state == ST_FLAGS)
        else $error("idle request bits not published");
    chk_entry_limit: assert property (
        int'(entry_count) <= LP_TOTAL && (state != ST_ENTRY ||
        mem.addr < base +
        32'(FLAG_OFFSET + (int'(entry_count) + 1) * ENTRY_LEN)))
        else $error("entry count beyond socket size");
    chk_drop_flag: assert property (
        accept && bad_req |=> status[ST_DROPPED_BIT] && state == ST_IDLE)
        else $error("refused update not reported");

    cov_change: cover property (acc_change ##[1:20] published);
    cov_idle: cover property (acc_idle ##[1:20] published);
    cov_drop: cover property (accept && bad_req);
    cov_irq: cover property (published ##1 irq);

endmodule : hint_table_writer

// >>> hw/hint_pkg.sv
package hint_pkg;

    // ------------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------------
    function automatic int count_ones(input logic [7:0] v);
        int n;
        n = 0;
        for (int k = 0; k < 8; k++) begin
            n = n + int'(v[k]);
        end
        return n;
    endfunction : count_ones

    // Lane zero is performance and lane one is energy efficiency
    // so a one-class table matches the older two-capability layout.
    localparam logic [7:0] CAP_MASK = 8'h03;
    localparam int CAPABILITY_TOTAL = count_ones(CAP_MASK);
    localparam int CATEGORY_TOTAL = 3;
    localparam int LP_TOTAL = 8;
    localparam int ROW_BYTES = CATEGORY_TOTAL * CAPABILITY_TOTAL;
    // Smallest padding to a multiple of eight bytes.
    localparam int PAD_BYTES = (8 - (ROW_BYTES % 8)) % 8;
    localparam int ENTRY_LEN = ROW_BYTES + PAD_BYTES;
    localparam int STAMP_OFFSET = 0;
    localparam int FLAG_OFFSET = 8;
    // Stamp plus the padded flag array, sixteen bytes or more.
    localparam int HEADER_LEN = FLAG_OFFSET + ENTRY_LEN;
    localparam logic [7:0] ROW_MASK = 8'(( 1 << ROW_BYTES) - 1);
    localparam logic [1:0] CAP_PERF = 2'h0;
    localparam logic [1:0] CAP_EFF = 2'h1;

    // ------------------------------------------------------------------
    // Register map and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BASE = 8'h04;
    localparam logic [7:0] REG_ENTRIES = 8'h08;
    localparam logic [7:0] REG_IDENT_SEL = 8'h0C;
    localparam logic [7:0] REG_IDENT = 8'h10;
    localparam logic [7:0] REG_INT_STATUS = 8'h14;
    localparam logic [7:0] REG_INT_MASK = 8'h18;
    localparam logic [7:0] REG_STAMP_LO = 8'h1C;
    localparam logic [7:0] REG_STAMP_HI = 8'h20;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int ST_PUBLISHED_BIT = 0;
    localparam int ST_DROPPED_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;
    localparam logic [3:0] ENTRIES_RESET = 4'h8;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] lp;
        logic [1:0] cls;
        logic [1:0] cap;
        logic idle;
        logic [7:0] value;
    } upd_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
        logic [7:0] byte_en;
    } mem_wr_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ENTRY = 4'b0010,
        ST_FLAGS = 4'b0100,
        ST_STAMP = 4'b1000
    } pub_state_t;

endpackage : hint_pkg

// >>> hw/hint_layout.sv
`timescale 1ns/1ns
module hint_layout
    import hint_pkg::*;
(
    input wire logic [2:0] lp,
    input wire logic [1:0] cls,
    input wire logic [1:0] cap,
    output logic [15:0] entry_offset,
    output logic [2:0] lane
);

    // Entries follow the header back to back.
    assign entry_offset = 16'(FLAG_OFFSET + (int'(lp) + 1) * ENTRY_LEN);
    // Class-major lane order inside a row.
    assign lane = 3'(int'(cls) * CAPABILITY_TOTAL + int'(cap));

endmodule : hint_layout

// >>> dv/table_memory.sv
`timescale 1ns/1ns
module table_memory
    import hint_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire mem_wr_t mem,
    input wire logic mem_valid,
    output logic mem_ready,
    input wire logic slow,
    input wire logic [63:0] crystal_time
);
    logic [7:0] cells [0:127];
    logic [31:0] log_addr [$];
    logic [63:0] flag_time;
    logic [1:0] beat;

    initial begin
        foreach (cells[k]) cells[k] = 8'h00;
        flag_time = 64'h0000_0000_0000_0000;
    end

    // A slow memory takes one write in four cycles, to stretch the walk.
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            beat <= 2'h0;
            mem_ready <= 1'b0;
        end else begin
            beat <= beat + 2'h1;
            mem_ready <= !slow || (beat == 2'h2);
        end
    end

    always @(posedge clock) begin
        if (rst_b && mem_valid && mem_ready) begin
            log_addr.push_back(mem.addr);
            if (mem.addr[6:0] == 7'h08) flag_time = crystal_time;
            for (int b = 0; b < 8; b++) begin
                if (mem.byte_en[b]) begin
                    cells[{mem.addr[6:3], 3'(b)}] <= mem.data[8*b +: 8];
                end
            end
        end
    end
endmodule : table_memory

// >>> dv/hint_table_writer_tb.sv
`timescale 1ns/1ns
module hint_table_writer_tb
    import hint_pkg::*;
;
    localparam logic [31:0] BASE = 32'h0000_1000;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    upd_req_t upd = '0;
    logic upd_valid = 1'b0;
    logic upd_ready;
    mem_wr_t mem;
    logic mem_valid;
    logic mem_ready;
    logic slow = 1'b0;
    logic [63:0] crystal_time = 64'h0123_4567_89ab_0000;
    logic irq;
    logic [7:0] expect_cells [0:127];
    logic [63:0] exp_stamp = 64'h0000_0000_0000_0000;
    logic [1:0] exp_status = 2'h0;
    logic [1:0] exp_mask = 2'h0;
    upd_req_t r;
    int n_errors = 0;
    int check_count = 0;

    always #2 clock = ~clock;
    always @(posedge clock) crystal_time <= crystal_time + 64'h1;

    hint_table_writer hint_table_writer_inst (.clock(clock), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .upd(upd),
        .upd_valid(upd_valid), .upd_ready(upd_ready), .mem(mem),
        .mem_valid(mem_valid), .mem_ready(mem_ready),
        .crystal_time(crystal_time), .irq(irq));

    table_memory table_memory_inst (.clock(clock), .rst_b(rst_b), .mem(mem),
        .mem_valid(mem_valid), .mem_ready(mem_ready), .slow(slow),
        .crystal_time(crystal_time));

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : reg_wr

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check($sformatf("reg %h", a), reg_rdata, exp);
    endtask : rd_check

    task automatic wait_ready();
        int k;
        k = 0;
        #1;
        while (upd_ready !== 1'b1 && k < 300) begin
            @(posedge clock);
            #1;
            k++;
        end
        check("ready wait", k < 300, 1'b1);
    endtask : wait_ready

    // Expectations of one update are worked out here, not in the design.
    task automatic publish(input upd_req_t q);
        int eo;
        int n0;
        logic refused;
        logic changed;
        eo = 8 + (int'(q.lp) + 1) * ENTRY_LEN;
        eo = eo + CAPABILITY_TOTAL * int'(q.cls) + int'(q.cap);
        refused = q.lp >= 3'd5 || q.cls > 2'd2 || q.cap > 2'd1;
        if (q.idle) q.value = expect_cells[eo];
        changed = !refused && (q.idle || expect_cells[eo] !== q.value);
        n0 = table_memory_inst.log_addr.size();
        wait_ready();
        @(posedge clock);
        upd <= q;
        upd_valid <= 1'b1;
        @(posedge clock);
        upd_valid <= 1'b0;
        wait_ready();
        check("writes", table_memory_inst.log_addr.size() - n0,
              changed ? (q.idle ? 2 : 3) : 0);
        if (changed) begin
            if (!q.idle) expect_cells[eo] = q.value;
            expect_cells[8 + CAPABILITY_TOTAL * int'(q.cls) + int'(q.cap)] =
                {6'h0, q.idle, 1'b1};
            exp_stamp = table_memory_inst.flag_time;
            for (int b = 0; b < 8; b++) expect_cells[b] = exp_stamp[8*b +: 8];
            exp_status[0] = 1'b1;
            check("last", table_memory_inst.log_addr[$], BASE);
            check("flags", table_memory_inst.log_addr[$-1], BASE + 8);
        end
        if (changed && !q.idle) begin
            check("entry", table_memory_inst.log_addr[$-2],
                  BASE + 32'(8 + (int'(q.lp) + 1) * 8));
        end
        exp_status[1] = exp_status[1] | refused;
        foreach (expect_cells[b]) begin
            check($sformatf("cell %0d", b), table_memory_inst.cells[b],
                  expect_cells[b]);
        end
        rd_check(REG_STAMP_LO, exp_stamp[31:0]);
        rd_check(REG_STAMP_HI, exp_stamp[63:32]);
        rd_check(REG_INT_STATUS, 32'(exp_status));
        check("irq", irq, |(exp_status & exp_mask));
    endtask : publish

    task automatic upd_of(input int lp, input int c, input int p,
                          input logic i, input logic [7:0] v);
        r = '{lp: 3'(lp), cls: 2'(c), cap: 2'(p), idle: i, value: v};
        publish(r);
    endtask : upd_of

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (50000) @(posedge clock);
        n_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h1e5c));
        foreach (expect_cells[b]) expect_cells[b] = 8'h00;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        #1;
        check("ready", upd_ready, 1'b0);
        check("valid", mem_valid, 1'b0);
        rd_check(REG_CTRL, 32'h0000_0000);
        rd_check(REG_ENTRIES, 32'h0000_0008);
        rd_check(REG_INT_MASK, 32'h0000_0000);
        rd_check(8'h24, 32'h0000_0000);
        for (int s = 0; s < 8; s++) begin
            reg_wr(REG_IDENT_SEL, 32'(s));
            rd_check(REG_IDENT, {16'(s), 8'h03, 8'h03});
        end
        reg_wr(REG_IDENT, 32'hffff_ffff);
        rd_check(REG_IDENT, {16'h0007, 8'h03, 8'h03});
        reg_wr(REG_ENTRIES, 32'h0000_0009);
        rd_check(REG_ENTRIES, 32'h0000_0008);
        reg_wr(REG_ENTRIES, 32'h0000_0005);
        reg_wr(REG_BASE, BASE | 32'h0000_0003);
        rd_check(REG_BASE, BASE);
        exp_mask = 2'h1;
        reg_wr(REG_INT_MASK, 32'h0000_0001);
        reg_wr(REG_CTRL, 32'h0000_0001);
        for (int c = 0; c < 3; c++) begin
            for (int p = 0; p < 2; p++) upd_of(0, c, p, 1'b1, 8'h00);
        end
        upd_of(4, 2, 1, 1'b0, 8'hff);
        upd_of(0, 0, 0, 1'b0, 8'h00);
        upd_of(0, 0, 0, 1'b0, 8'h05);
        upd_of(0, 0, 1, 1'b0, 8'h09);
        upd_of(0, 0, 0, 1'b0, 8'h00);
        reg_wr(REG_INT_STATUS, 32'h0000_0001);
        exp_status = 2'h0;
        rd_check(REG_INT_STATUS, 32'h0000_0000);
        check("irq", irq, 1'b0);
        exp_mask = 2'h2;
        reg_wr(REG_INT_MASK, 32'h0000_0002);
        upd_of(1, 1, 0, 1'b0, 8'h44);
        upd_of(5, 0, 0, 1'b0, 8'h11);
        upd_of(1, 3, 0, 1'b0, 8'h11);
        upd_of(1, 0, 2, 1'b0, 8'h11);
        reg_wr(REG_INT_STATUS, 32'h0000_0003);
        exp_status = 2'h0;
        rd_check(REG_INT_STATUS, 32'h0000_0000);
        for (int n = 0; n < 40; n++) begin
            slow <= n >= 20;
            r.lp = 3'($urandom_range(4));
            r.cls = 2'($urandom_range(2));
            r.cap = 2'($urandom_range(1));
            r.idle = $urandom_range(7) == 0;
            r.value = 8'($urandom);
            publish(r);
        end
        complete_run();
    end
endmodule : hint_table_writer_tb
